// ==== rst_ctrl_defs.svh ====
// Constants of the reset source controller
`ifndef RST_CTRL_DEFS_SVH
`define RST_CTRL_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_PERIOD_NS           25
`define BROWNOUT_MIN_DURATION_NS  2000
`define BROWNOUT_MIN_CYCLES \
  ((`BROWNOUT_MIN_DURATION_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STARTUP_DELAY_PERIOD_NS   1638400
`define STARTUP_DELAY_CYCLES \
  ((`STARTUP_DELAY_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STARTUP_SHORT_PERIOD_NS   150
`define STARTUP_SHORT_CYCLES \
  ((`STARTUP_SHORT_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define CLKSEL_EXTRA_CYCLES       16
`define STARTUP_SHIFT_MEDIUM      2
`define STARTUP_SHIFT_FAST        4
`define CLKSEL_SLOW_BIT           0

// ****************************************************************
// Fuse codes and register map
// ****************************************************************
`define BROWNOUT_FUSE_OFF         3'h7
`define ADDR_CAUSE                5'h00
`define ADDR_IRQ_STATUS           5'h04
`define ADDR_IRQ_MASK             5'h08
`define ADDR_CONTROL              5'h0C
`define ADDR_STATE                5'h10
`define ADDR_LOW_BITS             5
`define SEL_NONE                  3'h0
`define SEL_CAUSE                 3'h1
`define SEL_IRQ_STATUS            3'h2
`define SEL_IRQ_MASK              3'h3
`define SEL_CONTROL               3'h4
`define SEL_STATE                 3'h5
`define CAUSE_WIDTH               5
`define CAUSE_POWER_ON            0
`define CTRL_BIT_CMP_BANDGAP      0
`define STATE_BIT_RESET           0
`define STATE_BIT_BANDGAP         1
`define STATE_BIT_BROWNOUT_EN     2
`define STATE_BIT_COUNTING        3
`define STATE_WIDTH               4
`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2

`endif

// ==== rst_ctrl_pkg.sv ====
// Types of the reset source controller
package rst_ctrl_pkg;

  // Reset cause flags, power-on in bit 0
  typedef struct packed {
    logic scan_reset_cause_flag;
    logic watchdog_cause_flag;
    logic brownout_cause_flag;
    logic pin_reset_cause_flag;
    logic power_on_cause_flag;
  } cause_flags_type;

  // Configuration fuses
  typedef struct packed {
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_fuse;
    logic [3:0] clock_select_fuse;
  } fuse_type;

  // Delay counter sequence
  typedef enum logic [1:0] {
    DELAY_HOLD,
    DELAY_COUNT,
    DELAY_RUN
  } delay_state_type;

endpackage

// ==== level_sync.sv ====
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_check
    $error("level_sync needs WIDTH of at least one");
  end

  // ****************************************************************
  // One chain per bit
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta;
    // First stage feeds only the second stage
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        meta        <= 1'h0;
        sync_out[i] <= 1'h0;
      end else begin
        meta        <= async_in[i];
        sync_out[i] <= meta;
      end
    end
  end

endmodule

// ==== persist_filter.sv ====
// Filter that reports a level only after it persists a minimum time
`timescale 1ns/10ps
module persist_filter #(
  parameter int COUNT = 80
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level,
  output logic      detected
);

  localparam int                WIDTH = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [WIDTH-1:0]  LAST  = WIDTH'(COUNT - 1);

  if (COUNT < 1) begin : g_check
    $error("persist_filter needs COUNT of at least one");
  end

  logic [WIDTH-1:0] count;

  // ****************************************************************
  // Persistence counter
  // ****************************************************************
  // Counts cycles of the level, saturates at the last step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!level) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + WIDTH'(1);
    end
  end

  // Short dips never reach the last step; recovery drops it at once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      detected <= 1'h0;
    end else begin
      detected <= level && (count == LAST);
    end
  end

endmodule

// ==== reset_source_controller.sv ====
// Reset source combiner, start-up delay, cause flags and bus registers
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "rst_ctrl_defs.svh"
module reset_source_controller #(
  parameter int ADDR_WIDTH          = 12,
  parameter int COUNT_WIDTH         = 20,
  parameter int DELAY_LONG_CYCLES   = `STARTUP_DELAY_CYCLES,
  parameter int BROWNOUT_MIN_CYCLES = `BROWNOUT_MIN_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [ADDR_WIDTH-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [ADDR_WIDTH-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire logic                  power_on_detect,
  input  wire logic                  reset_pin_n,
  input  wire logic                  brownout_low,
  input  wire logic                  watchdog_expire,
  input  wire logic                  watchdog_enable,
  input  wire logic                  scan_reset_bit,
  input  wire rst_ctrl_pkg::fuse_type fuses,
  input  wire logic                  adc_enable,
  output logic                       io_reset,
  output logic                       fetch_start,
  output logic                       bandgap_enable,
  output logic                       irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_WIDTH < `ADDR_LOW_BITS + 1) begin : g_addr_check
    $error("ADDR_WIDTH too small for the register map");
  end
  if (longint'(DELAY_LONG_CYCLES) + `CLKSEL_EXTRA_CYCLES
      >= (longint'(1) << COUNT_WIDTH)) begin : g_count_check
    $error("COUNT_WIDTH too small for the start-up delay");
  end
  if (DELAY_LONG_CYCLES < 1 || BROWNOUT_MIN_CYCLES < 1) begin : g_min_check
    $error("Delay counts must be at least one");
  end

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  // Brown-out detector runs unless the level fuse is left unprogrammed
  function automatic logic brownout_detector(input logic [2:0] level);
    brownout_detector = (level != `BROWNOUT_FUSE_OFF);
  endfunction

  // Terminal count of the delay counter from the two fuse groups
  function automatic logic [COUNT_WIDTH-1:0] delay_terminal(
    input rst_ctrl_pkg::fuse_type f
  );
    logic [COUNT_WIDTH-1:0] base;
    base = '0;
    case (f.startup_time_fuse)
      2'h0: base = COUNT_WIDTH'(`STARTUP_SHORT_CYCLES);
      2'h1: base = COUNT_WIDTH'(DELAY_LONG_CYCLES >> `STARTUP_SHIFT_FAST);
      2'h2: base = COUNT_WIDTH'(DELAY_LONG_CYCLES >> `STARTUP_SHIFT_MEDIUM);
      default: base = COUNT_WIDTH'(DELAY_LONG_CYCLES);
    endcase
    if (f.clock_select_fuse[`CLKSEL_SLOW_BIT]) begin
      base = base + COUNT_WIDTH'(`CLKSEL_EXTRA_CYCLES);
    end
    delay_terminal = base;
  endfunction

  // Register select from a byte address
  function automatic logic [2:0] reg_select(
    input logic [ADDR_WIDTH-1:0] addr
  );
    reg_select = `SEL_NONE;
    if ((addr >> `ADDR_LOW_BITS) == '0) begin
      case (addr[`ADDR_LOW_BITS-1:0])
        `ADDR_CAUSE:      reg_select = `SEL_CAUSE;
        `ADDR_IRQ_STATUS: reg_select = `SEL_IRQ_STATUS;
        `ADDR_IRQ_MASK:   reg_select = `SEL_IRQ_MASK;
        `ADDR_CONTROL:    reg_select = `SEL_CONTROL;
        `ADDR_STATE:      reg_select = `SEL_STATE;
        default:          reg_select = `SEL_NONE;
      endcase
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                         pon_sync;
  logic                         pin_low_sync;
  logic                         scan_sync;
  logic                         brownout_sync;
  logic                         brownout_on;
  logic                         brownout_reset;
  logic                         watchdog_prev;
  logic                         watchdog_pulse;
  logic                         async_set;
  logic                         hold_meta;
  logic                         hold_sync;
  rst_ctrl_pkg::delay_state_type state;
  logic [COUNT_WIDTH-1:0]       count;
  logic [COUNT_WIDTH-1:0]       terminal;
  rst_ctrl_pkg::cause_flags_type cause;
  rst_ctrl_pkg::cause_flags_type cause_set;
  rst_ctrl_pkg::cause_flags_type cause_prev;
  logic [`CAUSE_WIDTH-1:0]      irq_status;
  logic [`CAUSE_WIDTH-1:0]      irq_mask;
  logic                         comparator_bandgap_select;
  logic                         aw_held;
  logic [ADDR_WIDTH-1:0]        aw_addr;
  logic                         w_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         do_write;
  logic [2:0]                   wr_sel;
  logic                         wr_byte0;
  logic [`CAUSE_WIDTH-1:0]      cause_clear;
  logic [`CAUSE_WIDTH-1:0]      irq_clear;
  logic [2:0]                   rd_sel;
  logic [31:0]                  next_rdata;

  // ****************************************************************
  // Source conditioning
  // ****************************************************************
  // Pin-side levels are synchronised before the flag logic sees them
  level_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({power_on_detect, ~reset_pin_n, scan_reset_bit,
                brownout_low}),
    .sync_out ({pon_sync, pin_low_sync, scan_sync, brownout_sync})
  );

  assign brownout_on = brownout_detector(fuses.brownout_level_fuse);

  // Brown-out counts only while the detector is enabled
  persist_filter #(
    .COUNT    (BROWNOUT_MIN_CYCLES)
  ) u_brownout (
    .clock    (clock),
    .rst      (rst),
    .level    (brownout_sync & brownout_on),
    .detected (brownout_reset)
  );

  // Watchdog expiry gives a single-cycle pulse when enabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_prev  <= 1'h0;
      watchdog_pulse <= 1'h0;
    end else begin
      watchdog_prev  <= watchdog_expire;
      watchdog_pulse <= watchdog_expire & watchdog_enable
                        & ~watchdog_prev;
    end
  end

  // ****************************************************************
  // Reset combiner and delay counter
  // ****************************************************************
  // Asynchronous OR of every source; pin, power-on and scan work with the clock stopped, watchdog and brown-out need it
  assign async_set = rst | power_on_detect | ~reset_pin_n
                     | scan_reset_bit | watchdog_pulse
                     | brownout_reset;

  // Release of the combined reset brought onto the clock
  always_ff @(posedge clock or posedge async_set) begin
    if (async_set) begin
      hold_meta <= 1'h1;
      hold_sync <= 1'h1;
    end else begin
      hold_meta <= 1'h0;
      hold_sync <= hold_meta;
    end
  end

  assign terminal = delay_terminal(fuses);

  // Delay starts once every source is quiet, restarts on any new source
  always_ff @(posedge clock or posedge async_set) begin
    if (async_set) begin
      state <= rst_ctrl_pkg::DELAY_HOLD;
      count <= '0;
    end else begin
      case (state)
        rst_ctrl_pkg::DELAY_HOLD: begin
          if (!hold_sync) begin
            state <= rst_ctrl_pkg::DELAY_COUNT;
            count <= '0;
          end
        end
        rst_ctrl_pkg::DELAY_COUNT: begin
          if (count == terminal) begin
            state <= rst_ctrl_pkg::DELAY_RUN;
          end else begin
            count <= count + COUNT_WIDTH'(1);
          end
        end
        rst_ctrl_pkg::DELAY_RUN: begin
          state <= rst_ctrl_pkg::DELAY_RUN;
        end
        default: begin
          state <= rst_ctrl_pkg::DELAY_HOLD;
        end
      endcase
    end
  end

  // I/O reset set at once by any source, cleared after the delay
  always_ff @(posedge clock or posedge async_set) begin
    if (async_set) begin
      io_reset    <= 1'h1;
      fetch_start <= 1'h0;
    end else begin
      io_reset    <= (state != rst_ctrl_pkg::DELAY_RUN);
      fetch_start <= (state == rst_ctrl_pkg::DELAY_RUN) & io_reset;
    end
  end

  // ****************************************************************
  // Reference enable
  // ****************************************************************
  // Reference runs for brown-out, comparator or converter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bandgap_enable <= 1'h0;
    end else begin
      bandgap_enable <= brownout_on | comparator_bandgap_select
                        | adc_enable;
    end
  end

  // ****************************************************************
  // Cause flags and interrupts
  // ****************************************************************
  assign cause_set = '{scan_reset_cause_flag: scan_sync,
                       watchdog_cause_flag:   watchdog_pulse,
                       brownout_cause_flag:   brownout_reset,
                       pin_reset_cause_flag:  pin_low_sync,
                       power_on_cause_flag:   pon_sync};

  // Bus write strobes for the two clearable registers
  assign do_write    = aw_held & w_held & ~bvalid;
  assign wr_sel      = reg_select(aw_addr);
  assign wr_byte0    = do_write & w_strb[0];
  assign cause_clear = (wr_byte0 && wr_sel == `SEL_CAUSE)
                       ? ~w_data[`CAUSE_WIDTH-1:0] : '0;
  assign irq_clear   = (wr_byte0 && wr_sel == `SEL_IRQ_STATUS)
                       ? w_data[`CAUSE_WIDTH-1:0] : '0;

  // Flags survive internal reset, except that power-on clears the other four; a set in the clear cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause <= '0;
    end else begin
      cause.power_on_cause_flag <= cause_set.power_on_cause_flag
        | (cause.power_on_cause_flag
           & ~cause_clear[`CAUSE_POWER_ON]);
      cause[`CAUSE_WIDTH-1:1] <= cause_set[`CAUSE_WIDTH-1:1]
        | (cause[`CAUSE_WIDTH-1:1] & ~cause_clear[`CAUSE_WIDTH-1:1]
           & {(`CAUSE_WIDTH-1){~pon_sync}});
    end
  end

  // Sticky interrupt status on the rise of each cause, write one clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause_prev <= '0;
      irq_status <= '0;
      irq        <= 1'h0;
    end else begin
      cause_prev <= cause_set;
      irq_status <= (cause_set & ~cause_prev) | (irq_status & ~irq_clear);
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // Bus write channel
  // ****************************************************************
  assign awready = ~aw_held & ~bvalid;
  assign wready  = ~w_held & ~bvalid;

  // Address and data taken in either order, response after both
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'h0;
      aw_addr <= '0;
      w_held  <= 1'h0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'h0;
      bresp   <= `AXI_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'h1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'h1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'h0;
        w_held  <= 1'h0;
        bvalid  <= 1'h1;
        bresp   <= (wr_sel == `SEL_NONE || wr_sel == `SEL_STATE)
                   ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'h0;
      end
    end
  end

  // Writable control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask                  <= '0;
      comparator_bandgap_select <= 1'h0;
    end else if (wr_byte0) begin
      if (wr_sel == `SEL_IRQ_MASK) begin
        irq_mask <= w_data[`CAUSE_WIDTH-1:0];
      end
      if (wr_sel == `SEL_CONTROL) begin
        comparator_bandgap_select <= w_data[`CTRL_BIT_CMP_BANDGAP];
      end
    end
  end

  // ****************************************************************
  // Bus read channel
  // ****************************************************************
  assign arready = ~rvalid;
  assign rd_sel  = reg_select(araddr);

  // Read data mux, unused bits read as zero
  always_comb begin
    next_rdata = '0;
    case (rd_sel)
      `SEL_CAUSE:      next_rdata[`CAUSE_WIDTH-1:0] = cause;
      `SEL_IRQ_STATUS: next_rdata[`CAUSE_WIDTH-1:0] = irq_status;
      `SEL_IRQ_MASK:   next_rdata[`CAUSE_WIDTH-1:0] = irq_mask;
      `SEL_CONTROL:    next_rdata[`CTRL_BIT_CMP_BANDGAP] =
                         comparator_bandgap_select;
      `SEL_STATE: begin
        next_rdata[`STATE_BIT_RESET]       = io_reset;
        next_rdata[`STATE_BIT_BANDGAP]     = bandgap_enable;
        next_rdata[`STATE_BIT_BROWNOUT_EN] = brownout_on;
        next_rdata[`STATE_BIT_COUNTING]    =
          (state == rst_ctrl_pkg::DELAY_COUNT);
      end
      default:         next_rdata = '0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'h0;
      rdata  <= '0;
      rresp  <= `AXI_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'h1;
      rdata  <= next_rdata;
      rresp  <= (rd_sel == `SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'h0;
    end
  end

endmodule

// ==== reset_source_controller_chk.sv ====
// Port assertions for the reset source controller
`timescale 1ns/10ps
`include "rst_ctrl_defs.svh"
module reset_source_controller_chk #(
  parameter int BROWNOUT_MIN_CYCLES = `BROWNOUT_MIN_CYCLES
) (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   power_on_detect,
  input wire logic                   reset_pin_n,
  input wire logic                   brownout_low,
  input wire logic                   watchdog_expire,
  input wire logic                   watchdog_enable,
  input wire logic                   scan_reset_bit,
  input wire rst_ctrl_pkg::fuse_type fuses,
  input wire logic                   adc_enable,
  input wire logic                   io_reset,
  input wire logic                   fetch_start,
  input wire logic                   bandgap_enable
);
  // ****************
  // Helpers
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic       loud;
  logic [7:0] quiet_cnt;
  int         brown_cnt;
  // Any level source active
  assign loud = !reset_pin_n | power_on_detect | scan_reset_bit | brownout_low;
  // Cycles since all level sources went quiet
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      quiet_cnt <= 8'h00;
    else if (loud)
      quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hFF)
      quiet_cnt <= quiet_cnt + 8'h01;
  end
  // Cycles that an enabled brown-out has stood
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      brown_cnt <= 0;
    else if (brownout_low && fuses.brownout_level_fuse != `BROWNOUT_FUSE_OFF)
      brown_cnt <= brown_cnt + 1;
    else
      brown_cnt <= 0;
  end
  // ****************
  // Properties
  // ****************
  sequence s_wd_trig;
    watchdog_enable && $rose(watchdog_expire);
  endsequence
  sequence s_brown_long;
    brown_cnt >= BROWNOUT_MIN_CYCLES + 2;
  endsequence
  property p_pin;
    !reset_pin_n |-> io_reset;
  endproperty
  property p_por;
    power_on_detect |-> io_reset;
  endproperty
  property p_scan;
    scan_reset_bit |-> io_reset;
  endproperty
  property p_fetch;
    fetch_start |-> !io_reset && $past(io_reset) ##1 !fetch_start;
  endproperty
  property p_bandgap;
    fuses.brownout_level_fuse != 3'h7 || adc_enable |=> bandgap_enable;
  endproperty
  property p_wdog;
    s_wd_trig |-> ##[1:3] io_reset;
  endproperty
  property p_release;
    $fell(io_reset) |-> quiet_cnt >= 8'h05;
  endproperty
  property p_brown;
    s_brown_long |-> io_reset;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin low without reset");
  a_por: assert property (p_por)
    else $error("power-on without reset");
  a_scan: assert property (p_scan)
    else $error("scan bit without reset");
  a_fetch: assert property (p_fetch)
    else $error("fetch pulse wrong");
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap not enabled");
  a_wdog: assert property (p_wdog)
    else $error("watchdog gave no reset");
  a_release: assert property (p_release)
    else $error("reset released too early");
  a_brown: assert property (p_brown)
    else $error("brown-out gave no reset");
endmodule
bind reset_source_controller reset_source_controller_chk #(
  .BROWNOUT_MIN_CYCLES (BROWNOUT_MIN_CYCLES)
) u_reset_source_controller_chk (.*);

// ==== reset_source_model.sv ====
// Model of supply detectors, reset pin, watchdog and scan reset bit
`timescale 1ns/10ps
module reset_source_model (
  input  wire logic clock,
  output logic      power_on_detect,
  output logic      reset_pin_n,
  output logic      brownout_low,
  output logic      watchdog_expire,
  output logic      watchdog_enable,
  output logic      scan_reset_bit
);
  logic [4:0] act = 5'h01;
  // Watchdog starts disabled, supply starts below the power-on level
  initial watchdog_enable = 1'h0;
  // Active sources onto the lines, the pin is active low
  assign power_on_detect = act[0];
  assign reset_pin_n     = !act[1];
  assign brownout_low    = act[2];
  assign watchdog_expire = act[3];
  assign scan_reset_bit  = act[4];
  // Holds one source active for n cycles, then releases it
  task hold(input int sel, input int n);
    @(posedge clock);
    act[sel] <= 1'h1;
    repeat (n) @(posedge clock);
    act[sel] <= 1'h0;
  endtask
endmodule

// ==== reset_source_controller_tb.sv ====
// Self-checking bench for the reset source controller
`timescale 1ns/10ps
`include "rst_ctrl_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module reset_source_controller_tb;
  localparam logic [1:0] OK = `AXI_RESP_OKAY, ERR = `AXI_RESP_SLVERR;
  logic clock = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, adc_enable = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, bandgap_enable;
  logic power_on_detect, reset_pin_n, brownout_low, watchdog_expire;
  logic watchdog_enable, scan_reset_bit, io_reset, fetch_start;
  logic [11:0]            awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]            wdata = 32'h0, rdata, d;
  logic [3:0]             wstrb = 4'hF;
  logic [1:0]             bresp, rresp, r;
  rst_ctrl_pkg::fuse_type fuses = 9'h1C0;
  int                     failures = 0, total_checks = 0, cycles = 0;
  int                     term [5] = '{6, 4, 16, 64, 22};
  logic [8:0]             fz [5] = '{9'h1C0, 9'h1D0, 9'h1E0, 9'h1F0, 9'h1C1};
  reset_source_controller #(.DELAY_LONG_CYCLES(64), .BROWNOUT_MIN_CYCLES(4))
    u_reset_source_controller (.*);
  reset_source_model u_reset_source_model (.*);
  // Clock and hang guard
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // Bus write with response check
  task wc(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
    logic ta, tw, done;
    ta = 1'h0;
    tw = 1'h0;
    done = 1'h0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      #1;
      ta |= awvalid & awready;
      tw |= wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    `CHK("bresp", e, r)
  endtask
  // Bus read with data and response check
  task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, done;
    done = 1'h0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      #1;
      ta = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    `CHK("rdata", e, d)
    `CHK("rresp", er, r)
  endtask
  // Pulses a source and measures cycles until reset is released
  task rel(input int sel, input int n, input int lo, input int hi);
    int c;
    u_reset_source_model.hold(sel, n);
    c = 0;
    do begin
      @(posedge clock);
      c++;
      #1;
    end while (io_reset !== 1'h0 && c < 300);
    `CHK("release", 1'h1, (c >= lo && c <= hi))
    `CHK("fetch_start", 1'h1, fetch_start)
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    rel(0, 2, 11, 11);
    rc(12'h000, 32'h01, OK);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock) fuses <= fz[i];
      rel(1, 4, term[i] + 5, term[i] + 5);
    end
    rc(12'h000, 32'h03, OK);
    @(posedge clock) fuses <= 9'h1C0;
    rel(4, 20, 11, 11);
    rc(12'h000, 32'h13, OK);
    u_reset_source_model.hold(3, 2);
    wt(6);
    `CHK("io_reset", 1'h0, io_reset)
    @(posedge clock) u_reset_source_model.watchdog_enable <= 1'h1;
    rel(3, 2, 9, 16);
    rc(12'h000, 32'h1B, OK);
    rel(0, 3, 11, 11);
    rc(12'h000, 32'h01, OK);
    wc(12'h000, 32'h0, OK);
    rc(12'h000, 32'h0, OK);
    @(posedge clock) fuses <= 9'h100;
    u_reset_source_model.hold(2, 2);
    wt(8);
    `CHK("io_reset", 1'h0, io_reset)
    rc(12'h010, 32'h6, OK);
    rel(2, 12, 11, 16);
    rc(12'h000, 32'h04, OK);
    @(posedge clock) fuses <= 9'h1C0;
    @(posedge clock) adc_enable <= 1'h1;
    wt(2);
    `CHK("bandgap", 1'h1, bandgap_enable)
    @(posedge clock) adc_enable <= 1'h0;
    wc(12'h00C, 32'h1, OK);
    wt(2);
    `CHK("bandgap", 1'h1, bandgap_enable)
    wc(12'h00C, 32'h0, OK);
    wt(2);
    `CHK("bandgap", 1'h0, bandgap_enable)
    wc(12'h004, 32'h1F, OK);
    wc(12'h008, 32'h02, OK);
    rel(1, 4, 11, 11);
    `CHK("irq", 1'h1, irq)
    rc(12'h004, 32'h02, OK);
    wc(12'h004, 32'h02, OK);
    wt(2);
    `CHK("irq", 1'h0, irq)
    @(posedge clock) wstrb <= 4'hE;
    wc(12'h008, 32'h1F, OK);
    rc(12'h008, 32'h02, OK);
    @(posedge clock) wstrb <= 4'hF;
    wc(12'h008, 32'h0, OK);
    rel(1, 4, 11, 11);
    `CHK("irq", 1'h0, irq)
    rc(12'h020, 32'h0, ERR);
    wc(12'h010, 32'h1, ERR);
    end_of_test();
  end
endmodule
